// >>> rtl/io_logic_cell_gearbox.sv
// Per-pin I/O logic cell: delay line, I/O registers, DDR and 4:1/16:1 gearboxes, APB registers
// Summary of operation
// - Delay line of 128 steps, 30 ps each
// - Delay steps static or adjusted at run time
// - Delay serves input or output, never both
// - Input, output and tristate flops per pin
// - Clock enable polarity selectable per side
// - Rising or falling clock edge per side
// - Set/reset: sync, async, set, reset, off
// - Storage is flip-flop or transparent latch
// - Edge monitor works only in DDR mode
// - Pin is input, output, bidir or tristate
// - Basic mode bypasses all I/O registers
// - SDR mode routes through I/O registers
// - DDR input: two pad bits per word
// - DDR output: two bits per fabric period
// - Deserializer by four gives 4-bit words
// - Serializer by four shifts 4-bit words
// - By-sixteen modes only on large variant
// - Pad data output carries a simple serializer
// - Some small-variant pins lack I/O logic
`timescale 1ns/10ps
`include "io_logic_cell_defines.svh"

module io_logic_cell_gearbox
  import io_logic_cell_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter bit HAS_IO_LOGIC = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  input wire logic [15:0] core_output_data,
  input wire logic tristate_control,
  output logic [15:0] core_input_data,
  input wire logic io_clk,
  input wire logic in_ce,
  input wire logic out_ce,
  input wire logic in_side_set_reset,
  input wire logic out_side_set_reset,
  output logic fabric_clk,
  output logic word_strobe
);

  // Functions shared by several paths
  function automatic logic cfg_ok(input logic [31:0] w);
    logic [2:0] m;
    logic [1:0] ds;
    m = w[`CTRL_MODE_LSB +: 3];
    ds = w[`CTRL_DSEL_LSB +: 2];
    cfg_ok = 1'b1;
    if (m > MODE_SER16)
    begin
      cfg_ok = 1'b0;
    end
    if (ds == 2'h3)
    begin
      cfg_ok = 1'b0;
    end
    if (!LARGE_VARIANT && (m == MODE_DES16 || m == MODE_SER16))
    begin
      cfg_ok = 1'b0;
    end
    if (!HAS_IO_LOGIC && m != MODE_BASIC)
    begin
      cfg_ok = 1'b0;
    end
  endfunction

  function automatic logic addr_known(input logic [`ADDR_W-1:0] a);
    addr_known = (a == `OFS_CTRL) || (a == `OFS_REGCFG) || (a == `OFS_DELAY) ||
      (a == `OFS_DELAY_ADJ) || (a == `OFS_STATUS) || (a == `OFS_DATA_IN);
  endfunction

  function automatic logic [3:0] last_phase(input mode_e m);
    case (m)
      MODE_DDR: last_phase = 4'h1;
      MODE_DES4, MODE_SER4: last_phase = 4'h3;
      MODE_DES16, MODE_SER16: last_phase = 4'hf;
      default: last_phase = 4'h0;
    endcase
  endfunction

  // Register word to per-side config; reset and writes share one layout
  function automatic regcfg_s to_cfg(input logic [31:0] w);
    to_cfg.in_side = '{w[`CFG_IN_CE_HIGH_BIT], w[`CFG_IN_FALL_BIT], sr_mode_e'(w[`CFG_IN_SR_LSB +: 3])};
    to_cfg.out_side = '{w[`CFG_OUT_CE_HIGH_BIT], w[`CFG_OUT_FALL_BIT], sr_mode_e'(w[`CFG_OUT_SR_LSB +: 3])};
    to_cfg.latch = w[`CFG_LATCH_BIT];
  endfunction

  function automatic logic edge_seen(input logic fall, input logic cur, input logic prev);
    edge_seen = fall ? (prev & ~cur) : (~prev & cur);
  endfunction

  // One I/O storage element: flop or latch, CE polarity, set/reset style
  function automatic logic store_next(
    input logic d,
    input logic q,
    input logic hit,
    input logic open_lvl,
    input side_cfg_s c,
    input logic ce,
    input logic sr,
    input logic latch
  );
    logic take;
    logic ce_ok;
    ce_ok = c.ce_high ? ce : ~ce;
    take = (latch ? open_lvl : hit) & ce_ok;
    store_next = q;
    if (sr && c.sr == SR_ASYNC_SET)
    begin
      store_next = 1'b1;
    end
    else if (sr && c.sr == SR_ASYNC_RST)
    begin
      store_next = 1'b0;
    end
    else if (take)
    begin
      if (sr && c.sr == SR_SYNC_SET)
      begin
        store_next = 1'b1;
      end
      else if (sr && c.sr == SR_SYNC_RST)
      begin
        store_next = 1'b0;
      end
      else
      begin
        store_next = d;
      end
    end
  endfunction

  ctrl_s ctrl_r;
  regcfg_s cfg_r;
  logic [6:0] dly_static_r;
  logic [6:0] dly_dyn_r;
  logic edge_flag_r;
  logic em_prev_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic pad_s1_r;
  logic pad_s2_r;
  logic pad_hist_r;
  logic ioclk_s1_r;
  logic ioclk_s2_r;
  logic ioclk_s3_r;
  logic icap_r;
  logic odrv_r;
  logic tflop_r;
  logic [3:0] ph_r;
  logic [15:0] des_buf_r;
  logic [15:0] ser_word_r;
  logic [15:0] core_in_r;
  logic [1:0] out_hist_r;
  logic pad_out_r;
  logic pad_oe_r;
  logic fabric_clk_r;
  logic word_strobe_r;

  logic setup;
  logic access;
  logic wr_ok;
  logic [6:0] step_now;
  logic dly_on;
  logic pad_d;
  logic in_hit;
  logic out_hit;
  logic in_open;
  logic out_open;
  logic icap_nxt;
  logic odrv_nxt;
  logic tflop_nxt;
  logic [3:0] last;
  logic [3:0] ph_nxt;
  logic at_last;
  logic [15:0] mask;
  logic [15:0] des_word;
  logic out_bit_nxt;
  logic oe_nxt;
  logic gear_in;
  logic gear_out;
  logic [31:0] rd_mux;
  logic [31:0] status;
  logic edge_evt;

  // APB slave, zero wait states
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_r;
  assign wr_ok = access & pwrite & ~pslverr_r;

  assign status = {20'h0_0000, dly_on, HAS_IO_LOGIC, LARGE_VARIANT, edge_flag_r, 1'b0, step_now};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: rd_mux = {19'h0_0000, ctrl_r.dyn, 2'h0, ctrl_r.dsel, 2'h0, ctrl_r.dir, 1'b0, ctrl_r.mode};
      `OFS_REGCFG: rd_mux = {19'h0_0000, cfg_r.latch, 1'b0, cfg_r.out_side.sr, 1'b0, cfg_r.in_side.sr,
        cfg_r.out_side.fall, cfg_r.in_side.fall, cfg_r.out_side.ce_high, cfg_r.in_side.ce_high};
      `OFS_DELAY: rd_mux = {25'h000_0000, dly_static_r};
      `OFS_STATUS: rd_mux = status;
      `OFS_DATA_IN: rd_mux = {16'h0000, core_in_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= setup;
      // Rejected configurations answer with an error and leave the cell as it was
      pslverr_r <= setup & (~addr_known(paddr) |
        (pwrite & (paddr == `OFS_CTRL) & ~cfg_ok(pwdata)));
      prdata_r <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= ctrl_s'(8'(`CTRL_RESET));
      cfg_r <= to_cfg(`REGCFG_RESET);
    end
    else if (wr_ok && paddr == `OFS_CTRL)
    begin
      ctrl_r.mode <= mode_e'(pwdata[`CTRL_MODE_LSB +: 3]);
      ctrl_r.dir <= dir_e'(pwdata[`CTRL_DIR_LSB +: 2]);
      ctrl_r.dsel <= dsel_e'(pwdata[`CTRL_DSEL_LSB +: 2]);
      ctrl_r.dyn <= pwdata[`CTRL_DYN_BIT];
    end
    else if (wr_ok && paddr == `OFS_REGCFG)
    begin
      cfg_r <= to_cfg(pwdata);
    end
  end

  // Delay line: static count, or run-time steps starting from it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dly_static_r <= `DELAY_RESET;
      dly_dyn_r <= `DELAY_RESET;
    end
    else if (wr_ok && paddr == `OFS_DELAY)
    begin
      dly_static_r <= pwdata[6:0];
      dly_dyn_r <= pwdata[6:0];
    end
    else if (wr_ok && paddr == `OFS_DELAY_ADJ && ctrl_r.dyn)
    begin
      if (pwdata[`ADJ_INC_BIT] && dly_dyn_r != `STEP_MAX)
      begin
        dly_dyn_r <= dly_dyn_r + 7'h01;
      end
      else if (pwdata[`ADJ_DEC_BIT] && dly_dyn_r != 7'h00)
      begin
        dly_dyn_r <= dly_dyn_r - 7'h01;
      end
    end
  end

  // Sub-cycle delay rounds to the nearest whole clock: past half a period adds one
  assign step_now = ctrl_r.dyn ? dly_dyn_r : dly_static_r;
  assign dly_on = (step_now >= 7'(`DLY_HALF_STEPS));

  // Pad and I/O clock synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_s1_r <= 1'b0;
      pad_s2_r <= 1'b0;
      pad_hist_r <= 1'b0;
      ioclk_s1_r <= 1'b0;
      ioclk_s2_r <= 1'b0;
      ioclk_s3_r <= 1'b0;
    end
    else
    begin
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
      pad_hist_r <= pad_s2_r;
      ioclk_s1_r <= io_clk;
      ioclk_s2_r <= ioclk_s1_r;
      ioclk_s3_r <= ioclk_s2_r;
    end
  end

  assign pad_d = (ctrl_r.dsel == DSEL_INPUT && dly_on) ? pad_hist_r : pad_s2_r;
  assign in_hit = edge_seen(cfg_r.in_side.fall, ioclk_s2_r, ioclk_s3_r);
  assign out_hit = edge_seen(cfg_r.out_side.fall, ioclk_s2_r, ioclk_s3_r);
  assign in_open = cfg_r.in_side.fall ? ~ioclk_s2_r : ioclk_s2_r;
  assign out_open = cfg_r.out_side.fall ? ~ioclk_s2_r : ioclk_s2_r;

  // The three I/O storage elements
  assign icap_nxt = store_next(pad_d, icap_r, in_hit, in_open, cfg_r.in_side, in_ce,
    in_side_set_reset, cfg_r.latch);
  assign odrv_nxt = store_next(core_output_data[0], odrv_r, out_hit, out_open, cfg_r.out_side, out_ce,
    out_side_set_reset, cfg_r.latch);
  assign tflop_nxt = store_next(tristate_control, tflop_r, out_hit, out_open, cfg_r.out_side, out_ce,
    out_side_set_reset, cfg_r.latch);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      icap_r <= 1'b0;
      odrv_r <= 1'b0;
      tflop_r <= 1'b1;
    end
    else
    begin
      icap_r <= icap_nxt;
      odrv_r <= odrv_nxt;
      tflop_r <= tflop_nxt;
    end
  end

  // Gearbox phase: fabric period is a fixed multiple of the pad clock
  assign last = last_phase(ctrl_r.mode);
  assign at_last = (ph_r >= last);
  assign ph_nxt = at_last ? 4'h0 : ph_r + 4'h1;
  assign mask = 16'hffff >> (4'hf - last);
  assign gear_in = (ctrl_r.mode == MODE_DDR) || (ctrl_r.mode == MODE_DES4) || (ctrl_r.mode == MODE_DES16);
  assign gear_out = (ctrl_r.mode == MODE_DDR) || (ctrl_r.mode == MODE_SER4) || (ctrl_r.mode == MODE_SER16);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_r <= 4'h0;
      fabric_clk_r <= 1'b0;
      word_strobe_r <= 1'b0;
    end
    else
    begin
      ph_r <= ph_nxt;
      fabric_clk_r <= (ph_nxt <= (last >> 1)) && (last != 4'h0);
      word_strobe_r <= at_last;
    end
  end

  // Deserializer buffer: pad bit of phase i lands in bit i
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_des
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          des_buf_r[gi] <= 1'b0;
        end
        else if (gear_in && ph_r == 4'(gi))
        begin
          des_buf_r[gi] <= pad_d;
        end
      end
    end
  endgenerate

  always_comb
  begin
    des_word = des_buf_r;
    des_word[ph_r] = pad_d;
    des_word = des_word & mask;
  end

  // Word towards the fabric
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_in_r <= `WORD_RESET;
    end
    else if (ctrl_r.dir == DIR_OUTPUT || ctrl_r.dir == DIR_TRI_OUT)
    begin
      core_in_r <= `WORD_RESET;
    end
    else if (ctrl_r.mode == MODE_BASIC)
    begin
      core_in_r <= {15'h0000, pad_d};
    end
    else if (gear_in)
    begin
      if (at_last)
      begin
        core_in_r <= des_word;
      end
    end
    else
    begin
      core_in_r <= {15'h0000, icap_nxt};
    end
  end

  // Edge monitor: pad transition right at the fabric edge means a bad window
  assign edge_evt = (ctrl_r.mode == MODE_DDR) && (ph_r == 4'h0) && (pad_d != em_prev_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      em_prev_r <= 1'b0;
      edge_flag_r <= 1'b0;
    end
    else
    begin
      em_prev_r <= pad_d;
      // A new event beats a same-cycle clear
      if (edge_evt)
      begin
        edge_flag_r <= 1'b1;
      end
      else if (wr_ok && paddr == `OFS_STATUS && pwdata[`ST_EDGE_BIT])
      begin
        edge_flag_r <= 1'b0;
      end
    end
  end

  // Output serializer, loaded at the end of each fabric period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ser_word_r <= `WORD_RESET;
    end
    else if (gear_out && at_last)
    begin
      ser_word_r <= core_output_data & mask;
    end
  end

  always_comb
  begin
    out_bit_nxt = odrv_nxt;
    if (ctrl_r.mode == MODE_BASIC)
    begin
      out_bit_nxt = core_output_data[0];
    end
    else if (gear_out)
    begin
      out_bit_nxt = ser_word_r[ph_r];
    end
    case (ctrl_r.dir)
      DIR_INPUT: oe_nxt = 1'b0;
      DIR_OUTPUT: oe_nxt = 1'b1;
      default: oe_nxt = (ctrl_r.mode == MODE_BASIC) ? ~tristate_control : ~tflop_nxt;
    endcase
  end

  // Pad drive, optionally through the delay line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_hist_r <= 2'h0;
      pad_out_r <= 1'b0;
      pad_oe_r <= 1'b0;
    end
    else
    begin
      out_hist_r <= {oe_nxt, out_bit_nxt};
      if (ctrl_r.dsel == DSEL_OUTPUT && dly_on)
      begin
        pad_oe_r <= out_hist_r[1];
        pad_out_r <= out_hist_r[0];
      end
      else
      begin
        pad_oe_r <= oe_nxt;
        pad_out_r <= out_bit_nxt;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;
  assign core_input_data = core_in_r;
  assign fabric_clk = fabric_clk_r;
  assign word_strobe = word_strobe_r;

endmodule // io_logic_cell_gearbox

// >>> rtl/io_logic_cell_defines.svh
// Offsets, field positions, reset values and timing counts of the I/O logic cell
`ifndef IO_LOGIC_CELL_DEFINES_SVH
`define IO_LOGIC_CELL_DEFINES_SVH

`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_REGCFG 8'h04
`define OFS_DELAY 8'h08
`define OFS_DELAY_ADJ 8'h0c
`define OFS_STATUS 8'h10
`define OFS_DATA_IN 8'h14

`define CTRL_MODE_LSB 0
`define CTRL_DIR_LSB 4
`define CTRL_DSEL_LSB 8
`define CTRL_DYN_BIT 12

`define CFG_IN_CE_HIGH_BIT 0
`define CFG_OUT_CE_HIGH_BIT 1
`define CFG_IN_FALL_BIT 2
`define CFG_OUT_FALL_BIT 3
`define CFG_IN_SR_LSB 4
`define CFG_OUT_SR_LSB 8
`define CFG_LATCH_BIT 12

`define ADJ_INC_BIT 0
`define ADJ_DEC_BIT 1

`define ST_STEP_LSB 0
`define ST_EDGE_BIT 8
`define ST_LARGE_BIT 9
`define ST_HAS_IOL_BIT 10
`define ST_DLY_ON_BIT 11

`define CTRL_RESET 32'h0000_0000
`define REGCFG_RESET 32'h0000_0003
`define DELAY_RESET 7'h00
`define WORD_RESET 16'h0000

`define DELAY_STEPS 128
`define STEP_PS 30
`define CLK_PS 4000
`define DELAY_MAX_PS (`DELAY_STEPS * `STEP_PS)
`define DLY_HALF_STEPS ((`CLK_PS / 2 + `STEP_PS - 1) / `STEP_PS)
`define STEP_MAX 7'h7f

`endif

// >>> rtl/io_logic_cell_pkg.sv
// Types shared by the I/O logic cell
package io_logic_cell_pkg;

  typedef enum logic [2:0] {
    MODE_BASIC = 3'h0,
    MODE_SDR = 3'h1,
    MODE_DDR = 3'h2,
    MODE_DES4 = 3'h3,
    MODE_SER4 = 3'h4,
    MODE_DES16 = 3'h5,
    MODE_SER16 = 3'h6
  } mode_e;

  typedef enum logic [1:0] {
    DIR_INPUT = 2'h0,
    DIR_OUTPUT = 2'h1,
    DIR_BIDIR = 2'h2,
    DIR_TRI_OUT = 2'h3
  } dir_e;

  typedef enum logic [1:0] {
    DSEL_NONE = 2'h0,
    DSEL_INPUT = 2'h1,
    DSEL_OUTPUT = 2'h2
  } dsel_e;

  typedef enum logic [2:0] {
    SR_OFF = 3'h0,
    SR_SYNC_SET = 3'h1,
    SR_SYNC_RST = 3'h2,
    SR_ASYNC_SET = 3'h3,
    SR_ASYNC_RST = 3'h4
  } sr_mode_e;

  typedef struct packed {
    mode_e mode;
    dir_e dir;
    dsel_e dsel;
    logic dyn;
  } ctrl_s;

  typedef struct packed {
    logic ce_high;
    logic fall;
    sr_mode_e sr;
  } side_cfg_s;

  typedef struct packed {
    side_cfg_s in_side;
    side_cfg_s out_side;
    logic latch;
  } regcfg_s;

endpackage

// >>> tb/io_logic_cell_checker.sv
// Port checker for the I/O logic cell
`timescale 1ns/10ps
`include "io_logic_cell_defines.svh"

module io_logic_cell_checker
  import io_logic_cell_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter bit HAS_IO_LOGIC = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic [15:0] core_output_data,
  input wire logic tristate_control,
  input wire logic [15:0] core_input_data,
  input wire logic fabric_clk,
  input wire logic word_strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctrl_wr;
  logic quiet;
  ctrl_s ctrl_r;
  logic [3:0] age_r;
  assign ctrl_wr = psel && penable && pwrite && paddr == `OFS_CTRL;
  // Pipelines need time to settle after a mode change
  assign quiet = age_r > 4'h7;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= '0;
    else if (ctrl_wr && !pslverr)
      ctrl_r <= ctrl_s'({pwdata[2:0], pwdata[5:4], pwdata[9:8], pwdata[12]});
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_r <= 4'h0;
    else if (ctrl_wr)
      age_r <= 4'h0;
    else if (age_r != 4'hf)
      age_r <= age_r + 4'h1;
  end
  property p_dsel_reject;
    ctrl_wr && pwdata[9:8] == 2'h3 |-> pslverr;
  endproperty
  a_dsel_reject: assert property (p_dsel_reject) else $error("delay on both paths accepted");
  property p_large_only;
    ctrl_wr && !LARGE_VARIANT && (pwdata[2:0] == 3'h5 || pwdata[2:0] == 3'h6) |-> pslverr;
  endproperty
  a_large_only: assert property (p_large_only) else $error("by-sixteen mode accepted");
  property p_iol_absent;
    ctrl_wr && !HAS_IO_LOGIC && pwdata[2:0] != 3'h0 |-> pslverr;
  endproperty
  a_iol_absent: assert property (p_iol_absent) else $error("mode accepted without I/O logic");
  property p_input_no_oe;
    quiet && ctrl_r.dir == DIR_INPUT |-> !pad_oe;
  endproperty
  a_input_no_oe: assert property (p_input_no_oe) else $error("input pin drives pad");
  property p_basic_out;
    quiet && ctrl_r.mode == MODE_BASIC && ctrl_r.dir == DIR_OUTPUT && ctrl_r.dsel == DSEL_NONE
      |=> pad_out == $past(core_output_data[0]);
  endproperty
  a_basic_out: assert property (p_basic_out) else $error("basic output path wrong");
  property p_basic_tri;
    quiet && ctrl_r.mode == MODE_BASIC && ctrl_r.dir == DIR_TRI_OUT && ctrl_r.dsel == DSEL_NONE
      |=> pad_oe == !$past(tristate_control);
  endproperty
  a_basic_tri: assert property (p_basic_tri) else $error("basic tristate path wrong");
  property p_strobe_period;
    quiet && (ctrl_r.mode == MODE_SER4 || ctrl_r.mode == MODE_DES4) && word_strobe
      |=> (!word_strobe || !quiet) [*3] ##1 (word_strobe || !quiet);
  endproperty
  a_strobe_period: assert property (p_strobe_period) else $error("word period not four");
  property p_des_hold;
    quiet && ctrl_r.mode == MODE_DES4 && $changed(core_input_data)
      |=> ($stable(core_input_data) || !quiet) [*3];
  endproperty
  a_des_hold: assert property (p_des_hold) else $error("word not held a period");
  property p_ddr_fclk;
    quiet && ctrl_r.mode == MODE_DDR |-> fabric_clk != $past(fabric_clk);
  endproperty
  a_ddr_fclk: assert property (p_ddr_fclk) else $error("fabric clock not half pad rate");
  c_ser: cover property (quiet && ctrl_r.mode == MODE_SER4 && word_strobe);
  c_des: cover property (quiet && ctrl_r.mode == MODE_DES4 && $changed(core_input_data));
  c_ddr: cover property (quiet && ctrl_r.mode == MODE_DDR);
endmodule // io_logic_cell_checker

bind io_logic_cell_gearbox io_logic_cell_checker #(.LARGE_VARIANT(LARGE_VARIANT), .HAS_IO_LOGIC(HAS_IO_LOGIC))
  io_logic_cell_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .pad_out(pad_out), .pad_oe(pad_oe),
  .core_output_data(core_output_data), .tristate_control(tristate_control),
  .core_input_data(core_input_data), .fabric_clk(fabric_clk), .word_strobe(word_strobe));

// >>> tb/pad_far_end.sv
// Far side of the pad: pattern driver and pad wire level
`timescale 1ns/10ps

module pad_far_end
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drive_en,
  input wire logic [15:0] pattern,
  input wire logic pad_out,
  input wire logic pad_oe,
  output logic pad_level
);
  logic [3:0] idx_r;
  // One pad bit per pclk, index 0 first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idx_r <= 4'h0;
    else
      idx_r <= idx_r + 4'h1;
  end
  // Cell drive wins; a released wire rests on the weak pull-up
  assign pad_level = pad_oe ? pad_out : (drive_en ? pattern[idx_r] : 1'b1);
endmodule // pad_far_end

// >>> tb/io_logic_cell_gearbox_tb_top.sv
// Self-checking bench for the I/O logic cell
`timescale 1ns/10ps
`include "io_logic_cell_defines.svh"

module io_logic_cell_gearbox_tb_top;
  import io_logic_cell_pkg::*;
  typedef struct packed {logic [15:0] cfg; logic ce; logic pat; logic sr; logic lvl; logic exp;} step_s;
  logic pclk, pad_in, pready, pready_s, pslverr, pslverr_s, pad_out, pad_oe, fabric_clk, word_strobe, hit, a;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, io_clk = 1'b0, in_ce = 1'b0;
  logic out_ce = 1'b1, in_sr = 1'b0, out_sr = 1'b0, tc = 1'b0, drive_en = 1'b0, err, err_s;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, prdata_s, rd, rd_s, dbl;
  logic [15:0] core_output_data = 16'h0000, pattern = 16'h0000, core_input_data, s;
  logic [6:0] steps [3] = '{7'h42, 7'h43, 7'h7f};
  step_s seq [17] = '{{16'h0003, 5'b11011}, {16'h0003, 5'b11001}, {16'h0003, 5'b00011}, {16'h0003, 5'b00001},
    {16'h0002, 5'b00010}, {16'h0002, 5'b01000}, {16'h0006, 5'b01010}, {16'h0006, 5'b01001},
    {16'h0046, 5'b01100}, {16'h0036, 5'b00101}, {16'h0026, 5'b01101}, {16'h0026, 5'b01111},
    {16'h0026, 5'b01100}, {16'h1002, 5'b01011}, {16'h1002, 5'b00010}, {16'h1002, 5'b00000}, {16'h1002, 5'b01000}};
  int err_count = 0, cmp_count = 0, cyc = 0;

  io_logic_cell_gearbox io_logic_cell_gearbox_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .core_output_data(core_output_data),
    .tristate_control(tc), .core_input_data(core_input_data), .io_clk(io_clk), .in_ce(in_ce), .out_ce(out_ce),
    .in_side_set_reset(in_sr), .out_side_set_reset(out_sr), .fabric_clk(fabric_clk), .word_strobe(word_strobe));
  // Small variant without I/O logic shares the bus
  io_logic_cell_gearbox #(.LARGE_VARIANT(1'b0), .HAS_IO_LOGIC(1'b0)) io_logic_cell_gearbox_small_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s), .pad_in(pad_in), .pad_out(), .pad_oe(),
    .core_output_data(core_output_data), .tristate_control(tc), .core_input_data(), .io_clk(io_clk),
    .in_ce(in_ce), .out_ce(out_ce), .in_side_set_reset(in_sr), .out_side_set_reset(out_sr), .fabric_clk(),
    .word_strobe());
  pad_far_end pad_far_end_inst (.pclk(pclk), .presetn(presetn), .drive_en(drive_en), .pattern(pattern),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_level(pad_in));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Ends with one idle cycle so no signal is assigned twice at one edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1)
      tick(1);
    rd = prdata;
    rd_s = prdata_s;
    err = pslverr;
    err_s = pslverr_s;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic e);
    apb(1'b1, ad, d);
    chk("slave error", err, e);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0000_0000);
    chk($sformatf("register %h", ad), rd, e);
  endtask

  function automatic logic [31:0] cw(input mode_e m, input dir_e d, input dsel_e l, input logic y);
    return {19'h0, y, 2'h0, l, 2'h0, d, 1'b0, m};
  endfunction

  task automatic setc(input mode_e m, input dir_e d);
    wr(`OFS_CTRL, cw(m, d, DSEL_NONE, 1'b0), 1'b0);
    tick(12);
  endtask

  initial
  begin
    tick(5);
    presetn <= 1'b1;
    tick(1);
    rdc(`OFS_CTRL, `CTRL_RESET);
    rdc(`OFS_REGCFG, `REGCFG_RESET);
    rdc(`OFS_STATUS, 32'h0000_0600);
    chk("small status", rd_s, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped error", {rd, err}, 33'h0_0000_0001);
    wr(`OFS_CTRL, 32'h0000_0007, 1'b1);
    wr(`OFS_CTRL, 32'h0000_0301, 1'b1);
    rdc(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_CTRL, cw(MODE_DES16, DIR_INPUT, DSEL_NONE, 1'b0), 1'b0);
    chk("small by sixteen", err_s, 1'b1);
    wr(`OFS_CTRL, cw(MODE_SDR, DIR_INPUT, DSEL_NONE, 1'b0), 1'b0);
    chk("small sdr", err_s, 1'b1);
    $display("Test registers done");
    wr(`OFS_CTRL, cw(MODE_BASIC, DIR_INPUT, DSEL_INPUT, 1'b1), 1'b0);
    // 66 and 67 steps straddle half a pclk period
    foreach (steps[i])
    begin
      wr(`OFS_DELAY, {25'h0, steps[i]}, 1'b0);
      rdc(`OFS_STATUS, {20'h0, steps[i] > 7'h42, 2'h3, 2'h0, steps[i]});
    end
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        wr(`OFS_CTRL, cw(MODE_BASIC, DIR_INPUT, DSEL_INPUT, 1'b0), 1'b0);
      wr(`OFS_DELAY_ADJ, (i == 0 || i == 3) ? 32'h0000_0001 : 32'h0000_0002, 1'b0);
      apb(1'b0, `OFS_STATUS, 32'h0000_0000);
      chk("delay steps", rd[6:0], (i == 0 || i == 3) ? 7'h7f : (i == 1) ? 7'h7e : 7'h7d);
    end
    $display("Test delay done");
    core_output_data <= 16'h0001;
    for (int d = 0; d < 4; d++)
    begin
      setc(MODE_BASIC, dir_e'(d));
      chk("pad enable", {pad_oe, pad_out}, (d == 0) ? 2'b01 : 2'b11);
    end
    tc <= 1'b1;
    tick(4);
    chk("tristate release", pad_oe, 1'b0);
    tc <= 1'b0;
    drive_en <= 1'b1;
    pattern <= 16'hffff;
    setc(MODE_BASIC, DIR_INPUT);
    chk("basic input", core_input_data, 16'h0001);
    $display("Test basic done");
    setc(MODE_SDR, DIR_INPUT);
    foreach (seq[i])
    begin
      if (i == 0 || seq[i].cfg != seq[i - 1].cfg)
        wr(`OFS_REGCFG, {16'h0, seq[i].cfg}, 1'b0);
      in_ce <= seq[i].ce;
      pattern <= {16{seq[i].pat}};
      in_sr <= seq[i].sr;
      io_clk <= seq[i].lvl;
      tick(8);
      chk($sformatf("sdr step %0d", i), core_input_data, {15'h0, seq[i].exp});
    end
    wr(`OFS_REGCFG, `REGCFG_RESET, 1'b0);
    $display("Test sdr done");
    drive_en <= 1'b0;
    core_output_data <= 16'h000b;
    setc(MODE_SER4, DIR_OUTPUT);
    while (word_strobe !== 1'b1)
      tick(1);
    for (int i = 0; i < 4; i++)
    begin
      tick(1);
      chk("serial bit", pad_out, core_output_data[i]);
    end
    $display("Test serializer done");
    drive_en <= 1'b1;
    pattern <= 16'hb4e1;
    setc(MODE_DES4, DIR_INPUT);
    s = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      tick(4);
      s = {core_input_data[3:0], s[15:4]};
      chk("des upper bits", core_input_data[15:4], 12'h000);
    end
    // Any rotation of the pattern, bit 0 oldest
    dbl = {pattern, pattern};
    hit = 1'b0;
    for (int k = 0; k < 16; k++)
      hit = hit | (16'(dbl >> k) === s);
    chk("des bit order", hit, 1'b1);
    $display("Test deserializer done");
    pattern <= 16'haaaa;
    setc(MODE_DDR, DIR_INPUT);
    chk("ddr pair", {core_input_data[15:2], core_input_data[1] ^ core_input_data[0]}, 15'h0001);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("edge flag ddr", rd[8], 1'b1);
    setc(MODE_SDR, DIR_INPUT);
    wr(`OFS_STATUS, 32'h0000_0100, 1'b0);
    tick(8);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("edge flag sdr", rd[8], 1'b0);
    core_output_data <= 16'h0002;
    setc(MODE_DDR, DIR_OUTPUT);
    a = pad_out;
    tick(1);
    chk("ddr output toggle", pad_out ^ a, 1'b1);
    $display("Test ddr done");
    summarize();
  end
endmodule // io_logic_cell_gearbox_tb_top
